// File: logic/cpl_commutation_preset_loader.sv
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// - On load trigger, copy preset comparator 1 trigger enable into active register.
// - On load trigger, copy preset comparator 0 trigger enable into active register.
// - On load trigger, copy preset comparator 1 plus-input select into active register.
// - On load trigger, copy preset comparator 0 plus-input select into active register.
// - On load trigger, copy preset trigger-source field into active register.
// - Codes 000, 001, 010 trigger on timer 0, 1, 2 events.
// - Code 011 triggers on hall match; 100 comparator 0; 101 comparator 1.
// - Code 111 disables automatic loading; 110 is reserved, never triggers.
// - A three-bit software field holds the predicted next hall state.
// - Code 011: on any hall change, compare capture inputs with prediction; load on match.
// - On load trigger, copy all six override enables into active register.
// - On load trigger, copy all six override levels into active register.
// - Each output is overridden per the active enables and levels.
// - Enabled channel: level 0 forces output low, level 1 forces high.
module cpl_commutation_preset_loader #(
  parameter int NUM_OUT = cpl_pkg::NUM_OUT
) (
  input wire logic ref_clk,
  input wire logic rstn,
  // AXI4-Lite slave
  input wire logic [cpl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cpl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Trigger events, same clock
  input wire cpl_pkg::cpl_events_t events,
  // Timer 2 capture pins {input2, input1, input0}, asynchronous
  input wire logic [2:0] timer2CaptureIn,
  // Raw PWM generator outputs
  input wire logic [NUM_OUT-1:0] pwmIn,
  // Overridden PWM outputs
  output logic [NUM_OUT-1:0] pwmOut,
  // Active commutation word for comparator and PWM blocks
  output cpl_pkg::cpl_word_t activeCommutationReg,
  // Pulse: a phase change has just loaded
  output logic phaseLoaded
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Merge a write under byte strobes, keeping reserved bits at zero
  function automatic logic [31:0] strobeMerge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res & cpl_pkg::WMASK_PRESET;
  endfunction

  // Register decode, shared by read and write paths
  function automatic logic isMapped(input logic [cpl_pkg::ADDR_W-1:0] a);
    return (a == cpl_pkg::OFS_NEXT) || (a == cpl_pkg::OFS_ACTIVE);
  endfunction

  // Word returned for a read; unmapped addresses read as zero
  function automatic logic [31:0] readWord(
    input logic [cpl_pkg::ADDR_W-1:0] a,
    input cpl_pkg::cpl_word_t nextWord,
    input cpl_pkg::cpl_word_t activeWord
  );
    logic [31:0] res;
    res = '0;
    if (a == cpl_pkg::OFS_NEXT) begin
      res = nextWord;
    end else if (a == cpl_pkg::OFS_ACTIVE) begin
      res = activeWord;
    end
    return res;
  endfunction

  // ****************************************************************
  // Write channel
  // ****************************************************************
  logic awReady_r, awReady_nxt;
  logic awHeld_r, awHeld_nxt;
  logic [cpl_pkg::ADDR_W-1:0] awAddr_r, awAddr_nxt;
  logic wReady_r, wReady_nxt;
  logic wHeld_r, wHeld_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic [3:0] wStrb_r, wStrb_nxt;
  logic bValid_r, bValid_nxt;
  logic [1:0] bResp_r, bResp_nxt;
  logic doWrite;

  // Address and data taken in either order; answer once both held
  always_comb begin
    awHeld_nxt = awHeld_r;
    awAddr_nxt = awAddr_r;
    wHeld_nxt = wHeld_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    bValid_nxt = bValid_r;
    bResp_nxt = bResp_r;
    doWrite = awHeld_r && wHeld_r && !bValid_r;
    if (s_axi_awvalid && awReady_r) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wReady_r) begin
      wHeld_nxt = 1'b1;
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
    end
    if (bValid_r && s_axi_bready) begin
      bValid_nxt = 1'b0;
    end
    if (doWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bValid_nxt = 1'b1;
      // Unmapped address: error answer, no register touched
      bResp_nxt = isMapped(awAddr_r) ? cpl_pkg::RESP_OKAY : cpl_pkg::RESP_SLVERR;
    end
    // Ready only while nothing is held, one write under way
    awReady_nxt = !awHeld_nxt && !bValid_nxt;
    wReady_nxt = !wHeld_nxt && !bValid_nxt;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      awReady_r <= 1'b1;
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
      wReady_r <= 1'b1;
      wHeld_r <= 1'b0;
      wData_r <= '0;
      wStrb_r <= '0;
      bValid_r <= 1'b0;
      bResp_r <= cpl_pkg::RESP_OKAY;
    end else begin
      awReady_r <= awReady_nxt;
      awHeld_r <= awHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wReady_r <= wReady_nxt;
      wHeld_r <= wHeld_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      bValid_r <= bValid_nxt;
      bResp_r <= bResp_nxt;
    end
  end

  // ****************************************************************
  // Hall input synchroniser
  // ****************************************************************
  logic [2:0] hallMeta_r, hallMeta_nxt;
  logic [2:0] hallSync_r, hallSync_nxt;
  logic [2:0] hallPrev_r, hallPrev_nxt;
  logic [2:0] hallPrimed_r, hallPrimed_nxt;

  // Pins are asynchronous; only the second and third stages feed logic
  always_comb begin
    hallMeta_nxt = timer2CaptureIn;
    hallSync_nxt = hallMeta_r;
    hallPrev_nxt = hallSync_r;
    // Stages reset to zero, not to the pin level, so wait for real samples
    hallPrimed_nxt = {hallPrimed_r[1:0], 1'b1};
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hallMeta_r <= '0;
      hallSync_r <= '0;
      hallPrev_r <= '0;
      hallPrimed_r <= '0;
    end else begin
      hallMeta_r <= hallMeta_nxt;
      hallSync_r <= hallSync_nxt;
      hallPrev_r <= hallPrev_nxt;
      hallPrimed_r <= hallPrimed_nxt;
    end
  end

  // ****************************************************************
  // Load trigger
  // ****************************************************************
  cpl_pkg::cpl_word_t next_r, next_nxt;
  cpl_pkg::cpl_word_t active_r, active_nxt;
  logic hallChange;
  logic hallMatch;
  logic loadTrigger;

  // Trigger picked by the source field of the active word
  always_comb begin
    // Gated until primed: a false edge after reset would commutate
    hallChange = hallPrimed_r[2] && (hallSync_r != hallPrev_r);
    // Prediction is always taken from the preset copy
    hallMatch = hallChange && (hallSync_r == next_r.predictedHallState);
    unique case (active_r.phaseTriggerSource)
      cpl_pkg::TRG_TIMER0: loadTrigger = events.timer[0];
      cpl_pkg::TRG_TIMER1: loadTrigger = events.timer[1];
      cpl_pkg::TRG_TIMER2: loadTrigger = events.timer[2];
      cpl_pkg::TRG_HALL: loadTrigger = hallMatch;
      cpl_pkg::TRG_CMP0: loadTrigger = events.comparatorZero;
      cpl_pkg::TRG_CMP1: loadTrigger = events.comparatorOne;
      cpl_pkg::TRG_RSVD: loadTrigger = 1'b0;
      cpl_pkg::TRG_OFF: loadTrigger = 1'b0;
    endcase
  end

  // ****************************************************************
  // Preset and active word
  // ****************************************************************
  logic loaded_r, loaded_nxt;
  logic writeNext;
  logic writeActive;

  // Software writes and the hardware load; the load wins a tie
  always_comb begin
    writeNext = doWrite && (awAddr_r == cpl_pkg::OFS_NEXT);
    writeActive = doWrite && (awAddr_r == cpl_pkg::OFS_ACTIVE);
    next_nxt = next_r;
    active_nxt = active_r;
    if (writeNext) begin
      next_nxt = strobeMerge(next_r, wData_r, wStrb_r);
    end
    if (writeActive) begin
      active_nxt = strobeMerge(active_r, wData_r, wStrb_r);
    end
    // Whole word in one edge, so no mix of old and new fields
    if (loadTrigger) begin
      active_nxt = next_r;
    end
    loaded_nxt = loadTrigger;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      next_r <= cpl_pkg::RST_NEXT;
      active_r <= cpl_pkg::RST_ACTIVE;
      loaded_r <= 1'b0;
    end else begin
      next_r <= next_nxt;
      active_r <= active_nxt;
      loaded_r <= loaded_nxt;
    end
  end

  // ****************************************************************
  // Output override
  // ****************************************************************
  logic [NUM_OUT-1:0] pwmOut_r, pwmOut_nxt;

  // Override uses the word now active, one cycle after the load
  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      pwmOut_nxt[i] = active_r.overrideEnable[i] ?
                      active_r.overrideLevel[i] : pwmIn[i];
    end
  end

  // Registered so the pins never glitch while the word changes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pwmOut_r <= '0;
    end else begin
      pwmOut_r <= pwmOut_nxt;
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  logic arReady_r, arReady_nxt;
  logic rValid_r, rValid_nxt;
  logic [31:0] rData_r, rData_nxt;
  logic [1:0] rResp_r, rResp_nxt;

  // One read at a time; data captured when the address is taken
  always_comb begin
    arReady_nxt = arReady_r;
    rValid_nxt = rValid_r;
    rData_nxt = rData_r;
    rResp_nxt = rResp_r;
    if (rValid_r && s_axi_rready) begin
      rValid_nxt = 1'b0;
      arReady_nxt = 1'b1;
    end
    if (s_axi_arvalid && arReady_r) begin
      arReady_nxt = 1'b0;
      rValid_nxt = 1'b1;
      // Snapshot at the address edge; a load one cycle later shows next read
      rResp_nxt = isMapped(s_axi_araddr) ? cpl_pkg::RESP_OKAY : cpl_pkg::RESP_SLVERR;
      rData_nxt = readWord(s_axi_araddr, next_r, active_r);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      arReady_r <= 1'b1;
      rValid_r <= 1'b0;
      rData_r <= '0;
      rResp_r <= cpl_pkg::RESP_OKAY;
    end else begin
      arReady_r <= arReady_nxt;
      rValid_r <= rValid_nxt;
      rData_r <= rData_nxt;
      rResp_r <= rResp_nxt;
    end
  end

  // ****************************************************************
  // Outputs, all from flip-flops
  // ****************************************************************
  assign s_axi_awready = awReady_r;
  assign s_axi_wready = wReady_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
  assign pwmOut = pwmOut_r;
  assign activeCommutationReg = active_r;
  assign phaseLoaded = loaded_r;

endmodule // cpl_commutation_preset_loader

// File: common/cpl_pkg.sv
package cpl_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_ACTIVE = 8'h78;
  localparam logic [ADDR_W-1:0] OFS_NEXT = 8'h7c;
  localparam logic [31:0] RST_NEXT = 32'h00000000;
  localparam logic [31:0] RST_ACTIVE = 32'h00000000;
  // Writable bits; reserved bits read back as zero
  localparam logic [31:0] WMASK_PRESET = 32'h3f773f3f;

  // ****************************************************************
  // Bus answers
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Trigger source codes
  // ****************************************************************
  localparam logic [2:0] TRG_TIMER0 = 3'h0;
  localparam logic [2:0] TRG_TIMER1 = 3'h1;
  localparam logic [2:0] TRG_TIMER2 = 3'h2;
  localparam logic [2:0] TRG_HALL = 3'h3;
  localparam logic [2:0] TRG_CMP0 = 3'h4;
  localparam logic [2:0] TRG_CMP1 = 3'h5;
  localparam logic [2:0] TRG_RSVD = 3'h6;
  localparam logic [2:0] TRG_OFF = 3'h7;

  localparam int NUM_OUT = 6;

  // ****************************************************************
  // Commutation word, same layout for preset and active copies
  // ****************************************************************
  typedef struct packed {
    logic [1:0] rsv31;
    logic cmp1TriggerEnable;
    logic cmp0TriggerEnable;
    logic [1:0] cmp1PlusInputSelect;
    logic [1:0] cmp0PlusInputSelect;
    logic rsv23;
    logic [2:0] phaseTriggerSource;
    logic rsv19;
    logic [2:0] predictedHallState;
    logic [1:0] rsv15;
    logic [NUM_OUT-1:0] overrideEnable;
    logic [1:0] rsv7;
    logic [NUM_OUT-1:0] overrideLevel;
  } cpl_word_t;

  // Trigger events from neighbouring blocks, one-cycle pulses
  typedef struct packed {
    logic [2:0] timer;
    logic comparatorOne;
    logic comparatorZero;
  } cpl_events_t;

endpackage

// File: verif/cpl_commutation_preset_loader_monitor.sv
`timescale 1ns/1ps
// ****************************************
// Port checker for the preset loader
// ****************************************
module cpl_preset_monitor #(
  parameter int NUM_OUT = 6
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cpl_pkg::cpl_events_t events,
  input wire logic [NUM_OUT-1:0] pwmIn,
  input wire logic [NUM_OUT-1:0] pwmOut,
  input wire cpl_pkg::cpl_word_t activeCommutationReg,
  input wire logic phaseLoaded
);
  logic [2:0] sel;
  logic fire;
  logic [NUM_OUT-1:0] en;
  logic [NUM_OUT-1:0] lv;
  // Hall match is left out here: the sync delay hides it from the ports
  assign sel = activeCommutationReg.phaseTriggerSource;
  assign fire = (sel < 3'h3 && events.timer[sel[1:0]]) || (sel == 3'h4 && events.comparatorZero)
    || (sel == 3'h5 && events.comparatorOne);
  assign en = activeCommutationReg.overrideEnable;
  assign lv = activeCommutationReg.overrideLevel;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  AST_LOAD_ON_EVENT: assert property (fire |=> phaseLoaded)
    else $error("selected event gave no load");
  AST_NO_LOAD_OFF: assert property (sel[2:1] == 2'h3 |=> !phaseLoaded)
    else $error("load while source disabled");
  AST_LOAD_HAS_CAUSE: assert property (phaseLoaded |-> $past(fire || sel == 3'h3))
    else $error("load without its trigger");
  AST_PWM_MASK: assert property ($past(rstn) |->
    pwmOut == (($past(pwmIn) & ~$past(en)) | ($past(lv) & $past(en))))
    else $error("output override wrong");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[2:3] s_axi_bvalid)
    else $error("write answer late");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_AR_REFUSED: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");

  // Main scenarios reached
  CV_LOAD: cover property (phaseLoaded);
  CV_HALL: cover property (phaseLoaded && $past(sel) == 3'h3);
  CV_ERR: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // cpl_preset_monitor

// File: verif/cpl_commutation_preset_loader_bench.sv
`timescale 1ns/1ps
// ****************************************
// Bench with integer model of the words
// ****************************************
module cpl_commutation_preset_loader_bench;
  logic ref_clk = 0;
  logic rstn = 0;
  logic [7:0] awAddr = 0, arAddr = 0;
  logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic [31:0] wData = 0;
  logic [3:0] wStrb = 4'hf;
  logic [1:0] bResp, rResp;
  logic awReady, wReady, bValid, arReady, rValid, loaded;
  logic [31:0] rData;
  cpl_pkg::cpl_events_t ev = '0;
  logic [2:0] cap = 0;
  logic [5:0] pwmIn = 0, pwmOut;
  cpl_pkg::cpl_word_t act;
  int nFail = 0, nCompared = 0, seed = 32'h97cd305d, nLoads = 0, expLoads = 0;
  int pre, actM, c, k;
  // Model: words expected at each load, oldest first
  int expQ[$];

  cpl_commutation_preset_loader u_cpl_commutation_preset_loader (.ref_clk(ref_clk), .rstn(rstn),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .events(ev), .timer2CaptureIn(cap), .pwmIn(pwmIn), .pwmOut(pwmOut),
    .activeCommutationReg(act), .phaseLoaded(loaded));

  // Clock; every load is held against the model queue
  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (loaded === 1'b1) begin
      nLoads <= nLoads + 1;
      if (expQ.size() == 0) chk(loaded, 1'b0);
      else chk(act, expQ.pop_front());
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    nCompared++;
    if (seen !== want) begin
      nFail++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task wrapUp;
    $display("compared %0d, failed %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One write; trailing edge keeps bready from toggling twice in a step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awAddr <= a;
    wData <= d;
    awValid <= 1;
    wValid <= 1;
    bReady <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (awReady) awValid <= 0;
      if (wReady) wValid <= 0;
      if (bValid) break;
    end
    bReady <= 0;
    if (n == 40) begin nFail++; wrapUp(); end
    chk(bResp, er);
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] want, input logic [1:0] er);
    int n;
    arAddr <= a;
    arValid <= 1;
    rReady <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (arReady) arValid <= 0;
      if (rValid) break;
    end
    rReady <= 0;
    if (n == 40) begin nFail++; wrapUp(); end
    chk(rData, want);
    chk(rResp, er);
    @(posedge ref_clk);
  endtask

  // One-cycle event pulse, then let the load land
  task automatic fire(input logic [4:0] e);
    ev <= e;
    @(posedge ref_clk);
    ev <= '0;
    repeat (3) @(posedge ref_clk);
  endtask

  // Main sequence: every trigger code, wrong source first, then the right one for codes 0 to 5
  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1;
    @(posedge ref_clk);
    chk(act, 0);
    rd(cpl_pkg::OFS_NEXT, 0, 0);
    rd(cpl_pkg::OFS_ACTIVE, 0, 0);
    wr(8'h40, 32'hffffffff, 2'h2);
    rd(8'h40, 0, 2'h2);
    rd(cpl_pkg::OFS_NEXT, 0, 0);
    // One byte lane only; reserved bits 23 and 19 must stay zero
    wStrb <= 4'h4;
    wr(cpl_pkg::OFS_NEXT, 32'hffffffff, 0);
    wStrb <= 4'hf;
    rd(cpl_pkg::OFS_NEXT, 32'h00770000, 0);
    $display("register access done");
    for (c = 0; c < 8; c++) begin
      pre = ($random(seed) & cpl_pkg::WMASK_PRESET & ~32'h00700000) | (c << 20);
      pwmIn <= 6'($random(seed));
      cap <= ~pre[18:16];
      repeat (4) @(posedge ref_clk);
      wr(cpl_pkg::OFS_NEXT, pre, 0);
      rd(cpl_pkg::OFS_NEXT, pre, 0);
      actM = c << 20;
      wr(cpl_pkg::OFS_ACTIVE, actM, 0);
      k = (c < 3) ? (4 << c) : (c == 4) ? 1 : (c == 5) ? 2 : 0;
      fire(5'h1f & ~k[4:0]);
      // A hall change that misses the prediction must not load
      if (c == 3) begin
        cap <= pre[18:16] ^ 3'h1;
        repeat (5) @(posedge ref_clk);
      end
      chk(act, actM);
      if (c < 6) begin
        actM = pre;
        expLoads++;
        expQ.push_back(pre);
      end
      if (c == 3) begin
        cap <= pre[18:16];
        repeat (5) @(posedge ref_clk);
      end else fire((k == 0) ? 5'h1f : k[4:0]);
      chk(act, actM);
      chk(pwmOut, (pwmIn & ~actM[13:8]) | (actM[5:0] & actM[13:8]));
      $display("trigger code %0d done", c);
    end
    chk(nLoads, expLoads);
    wrapUp();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    nFail++;
    wrapUp();
  end
endmodule // cpl_commutation_preset_loader_bench

bind cpl_commutation_preset_loader cpl_preset_monitor #(.NUM_OUT(NUM_OUT)) u_cpl_preset_monitor (
  .ref_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .events, .pwmIn, .pwmOut, .activeCommutationReg, .phaseLoaded);
